/* File: include/epr_map.vh */
// register map and field constants for the emulated phy status and identifier bank
`ifndef EPR_MAP_VH
`define EPR_MAP_VH

`define EPR_ADDR_W 9
// word byte offsets on the device register space
`define EPR_OFS_BASIC_STATUS 9'h1C4
`define EPR_OFS_ID_HIGH 9'h1C8
`define EPR_OFS_ID_LOW 9'h1CC
// management register indices
`define EPR_IDX_BASIC_STATUS 5'h01
`define EPR_IDX_ID_HIGH 5'h02
`define EPR_IDX_ID_LOW 5'h03
// status bit positions
`define EPR_ST_T4 15
`define EPR_ST_TX_FD 14
`define EPR_ST_TX_HD 13
`define EPR_ST_10_FD 12
`define EPR_ST_10_HD 11
`define EPR_ST_T2_FD 10
`define EPR_ST_T2_HD 9
`define EPR_ST_EXT_STATUS 8
`define EPR_ST_RSVD 7
`define EPR_ST_NO_PREAMBLE 6
`define EPR_ST_AN_DONE 5
`define EPR_ST_REMOTE_FAULT 4
`define EPR_ST_AN_ABLE 3
`define EPR_ST_LINK_UP 2
`define EPR_ST_JABBER 1
`define EPR_ST_EXT_CAP 0
// identifier low field positions
`define EPR_IDL_ORG_LSB 10
`define EPR_IDL_MODEL_LSB 4
`define EPR_IDL_REV_LSB 0
// reset values (arbitrary neutral identity values)
`define EPR_RST_ID_HIGH 16'h1234
`define EPR_RST_ID_LOW 16'h5678
// emulated auto-negotiation run time after reset
`define EPR_AN_TIME_NS 200
`define EPR_CLK_NS 10
`define EPR_AN_CYCLES ((`EPR_AN_TIME_NS + `EPR_CLK_NS - 1) / `EPR_CLK_NS)

`endif

/* File: hw/epr_an_timer.v */
// emulated auto-negotiation completion timer
`timescale 1ns/10ps
`default_nettype none

module epr_an_timer (
    input wire clk_sys,
    input wire arst_n,
    input wire restart,
    output reg done_q
);
    `include "epr_map.vh"

    localparam integer AN_CYCLES_I = `EPR_AN_CYCLES;
    // run time fits eight bits, cut on purpose
    localparam [7:0] AN_CYCLES = AN_CYCLES_I[7:0];

    reg [7:0] cnt_q;

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 8'h00;
            done_q <= 1'b0;
        end else if (restart) begin
            cnt_q <= 8'h00;
            done_q <= 1'b0;
        end else if (!done_q) begin
            if (cnt_q == AN_CYCLES - 8'h01) begin
                done_q <= 1'b1;
            end
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule // epr_an_timer

`default_nettype wire

/* File: hw/epr_regs.v */
// emulated phy basic status and identifier register bank
//
// Behaviour
// - words are 32 bits, upper half zero; management reads return low 16 bits
// - status, id high, id low at indices 1,2,3; id high at byte 1C8h
// - status register is read-only; writes change nothing
// - status bits 15, 10, 9 always read zero
// - status bits 14 through 11 always read one
// - extended-status bit 8 always reads zero
// - bit 6 reads zero, preamble must always be sent
// - auto-negotiation complete clears on reset, sets after emulated negotiation
// - remote fault bit 4 and jabber bit 1 read zero
// - link status bit 2 always reads one
// - auto-negotiation ability bit 3 reads one
// - extended capability bit 0 reads one
// - id high bits 15:0 read/write, upper organization identifier
// - id low holds organization low six bits, model and revision, all read/write
// - soft reset returns every register, identifiers too, to default
`timescale 1ns/10ps
`default_nettype none

module epr_regs (
    input wire clk_sys,
    input wire arst_n,
    // device register space, 32-bit words
    input wire host_sel,
    input wire host_wr,
    input wire [8:0] host_addr,
    input wire [31:0] host_wdata,
    output reg [31:0] host_rdata_q,
    output reg host_ack_q,
    output reg host_err_q,
    // management frame engine, 16-bit registers by index
    input wire mgmt_sel,
    input wire mgmt_wr,
    input wire [4:0] mgmt_index,
    input wire [15:0] mgmt_wdata,
    output reg [15:0] mgmt_rdata_q,
    output reg mgmt_ack_q,
    // self-clearing reset bit from the emulated control register
    input wire emulated_phy_soft_reset,
    output reg an_done_q
);
    `include "epr_map.vh"

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    localparam [1:0] SEL_NONE = 2'h0;
    localparam [1:0] SEL_STATUS = 2'h1;
    localparam [1:0] SEL_ID_HIGH = 2'h2;
    localparam [1:0] SEL_ID_LOW = 2'h3;

    function [1:0] host_decode;
        input [8:0] a;
        begin
            case (a)
                `EPR_OFS_BASIC_STATUS: host_decode = SEL_STATUS;
                `EPR_OFS_ID_HIGH: host_decode = SEL_ID_HIGH;
                `EPR_OFS_ID_LOW: host_decode = SEL_ID_LOW;
                default: host_decode = SEL_NONE;
            endcase
        end
    endfunction

    function [1:0] mgmt_decode;
        input [4:0] i;
        begin
            case (i)
                `EPR_IDX_BASIC_STATUS: mgmt_decode = SEL_STATUS;
                `EPR_IDX_ID_HIGH: mgmt_decode = SEL_ID_HIGH;
                `EPR_IDX_ID_LOW: mgmt_decode = SEL_ID_LOW;
                default: mgmt_decode = SEL_NONE;
            endcase
        end
    endfunction

    wire [1:0] host_hit = host_decode(host_addr);
    wire [1:0] mgmt_hit = mgmt_decode(mgmt_index);

    // ------------------------------------------------------------
    // auto-negotiation emulation
    // ------------------------------------------------------------
    wire an_done;

    epr_an_timer u_an_timer (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .restart(emulated_phy_soft_reset),
        .done_q(an_done)
    );

    // ------------------------------------------------------------
    // status word
    // ------------------------------------------------------------
    reg [15:0] status;
    always @* begin
        status = 16'h0000;
        status[`EPR_ST_T4] = 1'b0;
        status[`EPR_ST_T2_FD] = 1'b0;
        status[`EPR_ST_T2_HD] = 1'b0;
        status[`EPR_ST_TX_FD] = 1'b1;
        status[`EPR_ST_TX_HD] = 1'b1;
        status[`EPR_ST_10_FD] = 1'b1;
        status[`EPR_ST_10_HD] = 1'b1;
        status[`EPR_ST_EXT_STATUS] = 1'b0;
        status[`EPR_ST_NO_PREAMBLE] = 1'b0;
        status[`EPR_ST_AN_DONE] = an_done;
        status[`EPR_ST_REMOTE_FAULT] = 1'b0;
        status[`EPR_ST_JABBER] = 1'b0;
        status[`EPR_ST_LINK_UP] = 1'b1;
        status[`EPR_ST_AN_ABLE] = 1'b1;
        status[`EPR_ST_EXT_CAP] = 1'b1;
    end

    // ------------------------------------------------------------
    // identifier registers
    // ------------------------------------------------------------
    reg [15:0] id_high_q;
    reg [15:0] id_low_q;

    // host write takes priority over a same-cycle management write
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            id_high_q <= `EPR_RST_ID_HIGH;
            id_low_q <= `EPR_RST_ID_LOW;
        end else if (emulated_phy_soft_reset) begin
            id_high_q <= `EPR_RST_ID_HIGH;
            id_low_q <= `EPR_RST_ID_LOW;
        end else if (host_sel && host_wr) begin
            if (host_hit == SEL_ID_HIGH) begin
                id_high_q <= host_wdata[15:0];
            end
            if (host_hit == SEL_ID_LOW) begin
                id_low_q <= host_wdata[15:0];
            end
        end else if (mgmt_sel && mgmt_wr) begin
            if (mgmt_hit == SEL_ID_HIGH) begin
                id_high_q <= mgmt_wdata;
            end
            if (mgmt_hit == SEL_ID_LOW) begin
                id_low_q <= mgmt_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    function [15:0] read_word;
        input [1:0] s;
        input [15:0] st;
        input [15:0] hi;
        input [15:0] lo;
        begin
            case (s)
                SEL_STATUS: read_word = st;
                SEL_ID_HIGH: read_word = hi;
                SEL_ID_LOW: read_word = lo;
                default: read_word = 16'h0000;
            endcase
        end
    endfunction

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            host_rdata_q <= 32'h00000000;
            host_ack_q <= 1'b0;
            host_err_q <= 1'b0;
            mgmt_rdata_q <= 16'h0000;
            mgmt_ack_q <= 1'b0;
            an_done_q <= 1'b0;
        end else begin
            host_ack_q <= host_sel;
            host_err_q <= host_sel && (host_hit == SEL_NONE);
            if (host_sel && !host_wr) begin
                host_rdata_q <= {16'h0000, read_word(host_hit, status, id_high_q,
                    id_low_q)};
            end
            mgmt_ack_q <= mgmt_sel;
            if (mgmt_sel && !mgmt_wr) begin
                mgmt_rdata_q <= read_word(mgmt_hit, status, id_high_q, id_low_q);
            end
            an_done_q <= an_done;
        end
    end
endmodule // epr_regs

`default_nettype wire

/* File: verif/epr_chk.sv */
// assertion checker for the emulated phy register bank
`timescale 1ns/10ps
`default_nettype none
module epr_chk (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic host_sel,
    input wire logic host_wr,
    input wire logic [8:0] host_addr,
    input wire logic [31:0] host_rdata_q,
    input wire logic host_ack_q,
    input wire logic host_err_q,
    input wire logic mgmt_sel,
    input wire logic mgmt_wr,
    input wire logic [4:0] mgmt_index,
    input wire logic [15:0] mgmt_rdata_q,
    input wire logic mgmt_ack_q,
    input wire logic emulated_phy_soft_reset,
    input wire logic an_done_q
);
// ----
// properties
// ----
default clocking @(posedge clk_sys); endclocking
default disable iff (!arst_n);
wire logic hmap = host_addr == 9'h1C4 || host_addr == 9'h1C8 || host_addr == 9'h1CC;
wire logic hst = host_sel && !host_wr && host_addr == 9'h1C4;
chk_host_ack: assert property (host_sel |=> host_ack_q)
    else $error("host ack missing");
chk_pad_zero: assert property (host_ack_q |-> host_rdata_q[31:16] == 16'h0000)
    else $error("padding not zero");
chk_st_fixed: assert property (hst |=> (host_rdata_q & 32'hFFDF) == 32'h780D)
    else $error("status constant bits wrong");
chk_mg_fixed: assert property (mgmt_sel && !mgmt_wr && mgmt_index == 5'h01 |-> ##1 (mgmt_rdata_q & 16'hFFDF) == 16'h780D)
    else $error("management status wrong");
chk_mgmt_ack: assert property (mgmt_sel |=> mgmt_ack_q)
    else $error("management ack missing");
chk_err_map: assert property (host_sel |=> host_err_q == !$past(hmap))
    else $error("error flag wrong");
chk_an_clear: assert property (emulated_phy_soft_reset |-> ##2 !an_done_q)
    else $error("negotiation done not cleared");
chk_an_fall: assert property ($fell(an_done_q) |-> $past(emulated_phy_soft_reset, 2))
    else $error("negotiation done dropped");
cover property (hst && an_done_q);
cover property ($fell(an_done_q));
cover property (host_err_q);
endmodule // epr_chk
`default_nettype wire

/* File: verif/epr_mgmt_model.sv */
// management frame engine model driving the register bank
`timescale 1ns/10ps
`default_nettype none
module epr_mgmt_model (
    input wire logic clk_sys,
    output var logic mgmt_sel = 1'b0,
    output var logic mgmt_wr = 1'b0,
    output var logic [4:0] mgmt_index = 5'h00,
    output var logic [15:0] mgmt_wdata = 16'h0000
);
// only whole frames with preamble reach the bank
task xfer(input logic w, input logic [4:0] i, input logic [15:0] d);
    @(posedge clk_sys);
    mgmt_sel <= 1'b1;
    mgmt_wr <= w;
    mgmt_index <= i;
    mgmt_wdata <= d;
    @(posedge clk_sys);
    mgmt_sel <= 1'b0;
    mgmt_wdata <= ~d;
endtask
endmodule // epr_mgmt_model
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking testbench for the emulated phy register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
logic clk_sys = 1'b0;
logic arst_n = 1'b0;
logic host_sel = 1'b0, host_wr = 1'b0, emulated_phy_soft_reset = 1'b0;
logic [8:0] host_addr = 9'h000;
logic [31:0] host_wdata = 32'h0, host_rdata_q, d;
logic host_ack_q, host_err_q, mgmt_sel, mgmt_wr, mgmt_ack_q, an_done_q;
logic [4:0] mgmt_index;
logic [15:0] mgmt_wdata, mgmt_rdata_q;
logic [33:0] hq[$], hn;
logic [16:0] mq[$], mn;
int n_errors = 0, check_count = 0, i;
always #5 clk_sys = ~clk_sys;
epr_regs dut (.clk_sys, .arst_n, .host_sel, .host_wr, .host_addr, .host_wdata, .host_rdata_q,
    .host_ack_q, .host_err_q, .mgmt_sel, .mgmt_wr, .mgmt_index, .mgmt_wdata, .mgmt_rdata_q,
    .mgmt_ack_q, .emulated_phy_soft_reset, .an_done_q);
epr_mgmt_model u_mgmt (.clk_sys, .mgmt_sel, .mgmt_wr, .mgmt_index, .mgmt_wdata);
// ----
// tasks
// ----
task conclude;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
task chk_host(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
        n_errors++;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
endtask
task chk_mgmt(input logic [15:0] got, input logic [15:0] exp);
    chk_host({16'h0000, got}, {16'h0000, exp});
endtask
task hx(input logic w, input logic [8:0] a, input logic [31:0] wd, input logic [33:0] n);
    @(posedge clk_sys);
    hq.push_back(n);
    host_sel <= 1'b1;
    host_wr <= w;
    host_addr <= a;
    host_wdata <= wd;
    @(posedge clk_sys);
    host_sel <= 1'b0;
endtask
task mx(input logic w, input logic [4:0] x, input logic [15:0] wd, input logic [16:0] n);
    mq.push_back(n);
    u_mgmt.xfer(w, x, wd);
endtask
task report(input string s);
    $display("test %s done", s);
endtask
// ----
// result watcher
// ----
always @(negedge clk_sys) begin
    if (host_ack_q === 1'b1) begin
        hn = hq.size() ? hq.pop_front() : 34'h0;
        chk_host({31'h0, host_err_q}, {31'h0, hn[32]});
        if (hn[33]) chk_host(host_rdata_q, hn[31:0]);
    end
    if (mgmt_ack_q === 1'b1) begin
        mn = mq.size() ? mq.pop_front() : 17'h0;
        if (mn[16]) chk_mgmt(mgmt_rdata_q, mn[15:0]);
    end
end
initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    conclude;
end
// ----
// scenarios
// ----
initial begin
    void'($urandom(32'h124DFDFB));
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    hx(1'b0, 9'h1C4, 32'h0, {2'b10, 32'h780D});
    hx(1'b0, 9'h1C8, 32'h0, {2'b10, 32'h1234});
    hx(1'b0, 9'h1CC, 32'h0, {2'b10, 32'h5678});
    mx(1'b0, 5'h01, 16'h0, {1'b1, 16'h780D});
    repeat (25) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_host({31'h0, an_done_q}, 32'h1);
    hx(1'b1, 9'h1C4, 32'hFFFFFFFF, 34'h0);
    hx(1'b0, 9'h1C4, 32'h0, {2'b10, 32'h782D});
    mx(1'b0, 5'h01, 16'h0, {1'b1, 16'h782D});
    report("status");
    for (i = 0; i < 8; i++) begin
        d = $urandom;
        hx(1'b1, 9'h1C8, d, 34'h0);
        hx(1'b0, 9'h1C8, 32'h0, {2'b10, 16'h0, d[15:0]});
        mx(1'b1, 5'h03, d[31:16], 17'h0);
        hx(1'b0, 9'h1CC, 32'h0, {2'b10, 16'h0, d[31:16]});
        mx(1'b0, 5'h02, 16'h0, {1'b1, d[15:0]});
    end
    report("identifiers");
    hx(1'b0, 9'h1D0, 32'h0, {2'b11, 32'h0});
    hx(1'b1, 9'h1C0, 32'h0, {2'b01, 32'h0});
    mx(1'b0, 5'h00, 16'h0, {1'b1, 16'h0});
    report("unmapped");
    @(posedge clk_sys);
    emulated_phy_soft_reset <= 1'b1;
    @(posedge clk_sys);
    emulated_phy_soft_reset <= 1'b0;
    hx(1'b0, 9'h1C8, 32'h0, {2'b10, 32'h1234});
    hx(1'b0, 9'h1CC, 32'h0, {2'b10, 32'h5678});
    hx(1'b0, 9'h1C4, 32'h0, {2'b10, 32'h780D});
    @(negedge clk_sys);
    chk_host({31'h0, an_done_q}, 32'h0);
    repeat (25) @(posedge clk_sys);
    hx(1'b0, 9'h1C4, 32'h0, {2'b10, 32'h782D});
    report("soft reset");
    for (i = 0; i < 10 && (hq.size() || mq.size()); i++) @(posedge clk_sys);
    if (hq.size() || mq.size()) n_errors++;
    conclude;
end
endmodule // tb_top
bind epr_regs epr_chk u_chk (.clk_sys, .arst_n, .host_sel, .host_wr, .host_addr, .host_rdata_q,
    .host_ack_q, .host_err_q, .mgmt_sel, .mgmt_wr, .mgmt_index, .mgmt_rdata_q, .mgmt_ack_q,
    .emulated_phy_soft_reset, .an_done_q);
`default_nettype wire
